// [bench/apc_motor_model.sv]
// Purpose: motor shaft with quadrature encoder facing the block
// Assumes: one encoder step every PERIOD clocks while turning
// Notes:   an outside push turns the shaft with the drive idle
`timescale 1ns/10ps
`default_nettype none
module apc_motor_model #(
  parameter int PERIOD = 8
) (
  input  wire logic clock_i,
  input  wire logic rstn_i,
  input  wire logic run_i,
  input  wire logic dir_i,
  input  wire logic push_i,
  input  wire logic push_dir_i,
  output logic      enc_a_o,
  output logic      enc_b_o
);
  logic [1:0] phase;
  int         cnt;
  logic       turn;
  logic       fwd;

  // shaft turns under the drive or an outside push
  assign turn = run_i | push_i;
  assign fwd  = push_i ? push_dir_i : dir_i; // push direction wins while pushing, else drive picks

  // ****************************************
  // phase stepping
  // ****************************************
  // steps only while turning; count restarts when still
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase <= 2'h0;
      cnt   <= 0;
    end else if (!turn) begin
      cnt <= 0;
    end else if (cnt == PERIOD - 1) begin
      cnt   <= 0;
      phase <= fwd ? phase + 2'h1 : phase - 2'h1;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // forward gives A,B = 00,10,11,01: A rises while B low
  assign enc_a_o = phase[1] ^ phase[0];
  assign enc_b_o = phase[1];
endmodule // apc_motor_model
`default_nettype wire

// [bench/test_absolute_position_control.sv]
// Purpose: self-checking bench for the position control block
// Assumes: encoder model steps every P clocks
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/10ps
`default_nettype none
`include "apc_params.svh"
module test_absolute_position_control;
  localparam int P = 8;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] vf_curve_select_i, control_pulse_setting_i, reset_mode_select_i;
  logic [7:0] display_group_select_i, terminal_function_i, menu_target_i;
  logic [3:0] menu_index_i;
  logic [2:0] teaching_slot_select_i, target_select_i;
  logic [1:0] zero_return_mode_i;
  logic [31:0] slow_distance_i;
  logic speed_position_select_terminal_i, position_counter_clear_terminal_i;
  logic torque_control_enable_terminal_i, pulse_train_enable_terminal_i;
  logic orientation_teach_terminal_i, reset_terminal_i, run_i;
  logic keypad_save_key_i, keypad_scroll_i, slot_select_load_i;
  logic zero_return_i, home_search_req_i, push, push_dir, enc_a, enc_b;
  logic auto_position_control_mode_o, motor_run_o, motor_dir_o, decel_o;
  logic servo_lock_o, position_done_o, home_search_o, zero_return_busy_o;
  logic user_menu_only_o, run_seen;
  logic [1:0] zero_return_mode_o;
  logic [31:0] position_o, deviation_o;
  logic [15:0] position_display_o;
  logic [2:0] teaching_slot_o;
  logic [7:0] menu_pointer_o;
  int n_errors = 0;
  int tests_run = 0;

  // ****************************************
  // clock, design and motor
  // ****************************************
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) if (motor_run_o === 1'b1) run_seen <= 1'b1;

  apc_top i_apc_top (
    .clock_i, .rstn_i, .vf_curve_select_i, .control_pulse_setting_i,
    .reset_mode_select_i, .display_group_select_i, .terminal_function_i,
    .speed_position_select_terminal_i, .position_counter_clear_terminal_i,
    .torque_control_enable_terminal_i, .pulse_train_enable_terminal_i,
    .orientation_teach_terminal_i, .reset_terminal_i, .run_i,
    .keypad_save_key_i, .keypad_scroll_i, .menu_index_i, .menu_target_i,
    .teaching_slot_select_i, .slot_select_load_i, .target_select_i,
    .zero_return_mode_i, .zero_return_i, .home_search_req_i,
    .enc_a_i(enc_a), .enc_b_i(enc_b), .slow_distance_i,
    .auto_position_control_mode_o, .motor_run_o, .motor_dir_o, .decel_o,
    .servo_lock_o, .position_done_o, .home_search_o, .zero_return_busy_o,
    .zero_return_mode_o, .position_o, .position_display_o, .deviation_o,
    .teaching_slot_o, .user_menu_only_o, .menu_pointer_o);

  apc_motor_model #(.PERIOD(P)) i_apc_motor_model (
    .clock_i, .rstn_i, .run_i(motor_run_o), .dir_i(motor_dir_o),
    .push_i(push), .push_dir_i(push_dir), .enc_a_o(enc_a), .enc_b_o(enc_b));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // turns the shaft by whole encoder cycles, then lets sync settle
  task automatic turn(input logic d, input int cycles);
    push_dir = d;
    push = 1'b1;
    tick(cycles * 4 * P);
    push = 1'b0;
    tick(8);
  endtask

  task automatic wait_lock;
    for (int i = 0; i < 2000 && servo_lock_o !== 1'b1; i++) tick(1);
  endtask

  task automatic position_counter_clear_terminal;
    position_counter_clear_terminal_i = 1'b1;
    tick(3);
    check(deviation_o, 32'h0);
    position_counter_clear_terminal_i = 1'b0;
    tick(2);
  endtask

  task automatic teach(input logic [2:0] slot);
    teaching_slot_select_i = slot;
    slot_select_load_i = 1'b1;
    tick(1);
    slot_select_load_i = 1'b0;
    tick(2);
    check(teaching_slot_o, slot);
    keypad_save_key_i = 1'b1;
    tick(2);
    keypad_save_key_i = 1'b0;
    tick(2);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_count;
    turn(1'b1, 3);
    check(position_o, 32'h3);
    turn(1'b0, 4);
    check(position_o, 32'hFFFFFFFF);
    check(position_display_o, 16'hFFFF);
    control_pulse_setting_i = `APC_PULSE_ABS_HIRES;
    turn(1'b1, 1);
    check(position_o, 32'h3);
    control_pulse_setting_i = `APC_PULSE_ABS;
    $display("test count done");
  endtask

  task automatic t_clear;
    position_counter_clear_terminal();
    check(position_o, 32'h0);
    turn(1'b1, 2);
    reset_mode_select_i = `APC_RESET_TRIP_ONLY;
    reset_terminal_i = 1'b1;
    tick(6);
    check(position_o, 32'h2);
    reset_terminal_i = 1'b0;
    tick(6);
    check(position_o, 32'h2);
    reset_mode_select_i = 8'h00;
    reset_terminal_i = 1'b1;
    tick(6);
    check(position_o, 32'h0);
    reset_terminal_i = 1'b0;
    tick(3);
    $display("test clear done");
  endtask

  task automatic t_teach_run;
    terminal_function_i = `APC_FUNC_ORIENT;
    orientation_teach_terminal_i = 1'b1;
    tick(4);
    teach(3'h0);
    turn(1'b1, 5);
    teach(3'h3);
    orientation_teach_terminal_i = 1'b0;
    position_counter_clear_terminal();
    target_select_i = 3'h3;
    tick(1);
    run_i = 1'b1;
    tick(3);
    check(motor_run_o, 1'b1);
    check(motor_dir_o, 1'b1);
    wait_lock();
    check(position_o, 32'h5);
    check(position_done_o, 1'b1);
    check(motor_run_o, 1'b0);
    check(deviation_o, 32'h0);
    run_i = 1'b0;
    tick(2);
    check(servo_lock_o, 1'b0);
    turn(1'b1, 2);
    torque_control_enable_terminal_i = 1'b1;
    pulse_train_enable_terminal_i = 1'b1;
    run_i = 1'b1;
    tick(3);
    check(motor_dir_o, 1'b0);
    check(decel_o, 1'b1);
    wait_lock();
    check(position_o, 32'h5);
    run_i = 1'b0;
    torque_control_enable_terminal_i = 1'b0;
    pulse_train_enable_terminal_i = 1'b0;
    tick(2);
    position_counter_clear_terminal();
    target_select_i = 3'h0;
    tick(1);
    run_seen = 1'b0;
    run_i = 1'b1;
    tick(3);
    check(position_done_o, 1'b1);
    check(run_seen, 1'b0);
    run_i = 1'b0;
    tick(2);
    $display("test teach run done");
  endtask

  task automatic t_mode;
    vf_curve_select_i = 8'h01;
    home_search_req_i = 1'b1;
    tick(2);
    check(home_search_o, 1'b1);
    run_i = 1'b1;
    tick(5);
    check(auto_position_control_mode_o, 1'b0);
    check(motor_run_o, 1'b0);
    run_i = 1'b0;
    vf_curve_select_i = `APC_VF_SENSOR_VECTOR;
    home_search_req_i = 1'b1;
    tick(3);
    check(home_search_o, 1'b0);
    zero_return_mode_i = 2'h2;
    zero_return_i = 1'b1;
    tick(3);
    check(zero_return_busy_o, 1'b1);
    check(zero_return_mode_o, 2'h2);
    check(home_search_o, 1'b0);
    {zero_return_i, home_search_req_i} = 2'h0;
    tick(2);
    terminal_function_i = `APC_FUNC_SPEED_POS;
    run_i = 1'b1;
    tick(3);
    check(position_done_o, 1'b0);
    speed_position_select_terminal_i = 1'b1;
    tick(2);
    check(position_done_o, 1'b1);
    run_i = 1'b0;
    speed_position_select_terminal_i = 1'b0;
    tick(2);
    $display("test mode done");
  endtask

  task automatic t_menu;
    display_group_select_i = `APC_DISP_USER_ONLY;
    tick(2);
    check(user_menu_only_o, 1'b1);
    display_group_select_i = 8'h00;
    menu_index_i = 4'h5;
    menu_target_i = 8'h1A;
    keypad_scroll_i = 1'b1;
    tick(1);
    keypad_scroll_i = 1'b0;
    tick(2);
    check(user_menu_only_o, 1'b0);
    check(menu_pointer_o, 8'h1A);
    menu_index_i = 4'hC;
    menu_target_i = 8'h33;
    keypad_scroll_i = 1'b1;
    tick(1);
    keypad_scroll_i = 1'b0;
    menu_index_i = 4'h5;
    tick(2);
    check(menu_pointer_o, 8'h1A);
    $display("test menu done");
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    {run_i, keypad_save_key_i, keypad_scroll_i, slot_select_load_i} = 4'h0;
    {zero_return_i, home_search_req_i, push, push_dir, run_seen} = 5'h0;
    {speed_position_select_terminal_i, reset_terminal_i} = 2'h0;
    {position_counter_clear_terminal_i, orientation_teach_terminal_i} = 2'h0;
    {torque_control_enable_terminal_i, pulse_train_enable_terminal_i} = 2'h0;
    {menu_index_i, menu_target_i, zero_return_mode_i} = 14'h0;
    {teaching_slot_select_i, target_select_i} = 6'h0;
    {reset_mode_select_i, display_group_select_i} = 16'h0;
    terminal_function_i = 8'h00;
    slow_distance_i = 32'h2;
    vf_curve_select_i = `APC_VF_SENSOR_VECTOR;
    control_pulse_setting_i = `APC_PULSE_ABS;
    tick(4);
    rstn_i = 1'b1;
    tick(4);
    check(position_o, 32'h0);
    check(teaching_slot_o, 3'h0);
    check(auto_position_control_mode_o, 1'b1);
    t_count();
    t_clear();
    t_teach_run();
    t_mode();
    t_menu();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    $display("watchdog expired at %0t", $time);
    end_sim();
  end
endmodule // test_absolute_position_control
`default_nettype wire

// [design/apc_enc_if.sv]
// Purpose: encoder step carrier between counter and control
// Assumes: one clock domain
// Notes:   step is one cycle per counted encoder edge
`timescale 1ns/10ps
`default_nettype none
interface apc_enc_if;
  logic             step;
  logic             up;
  logic             clear;
  apc_pkg::apc_pos_t pos;
  modport counter (input step, input up, input clear, output pos);
  modport control (output step, output up, output clear, input pos);
endinterface
`default_nettype wire

// [design/apc_params.svh]
// Purpose: constants for the absolute position control block
// Assumes: 100 MHz clock
// Notes:   codes are the setting values seen by the block
`ifndef APC_PARAMS_SVH
`define APC_PARAMS_SVH
`define APC_VF_SENSOR_VECTOR  8'h02
`define APC_PULSE_ABS         8'h02
`define APC_PULSE_ABS_HIRES   8'h03
`define APC_RESET_TRIP_ONLY   8'h03
`define APC_FUNC_SPEED_POS    8'h49
`define APC_FUNC_ORIENT       8'h2D
`define APC_DISP_USER_ONLY    8'h02
`define APC_SLOT_COUNT        8
`define APC_MENU_COUNT        12
`define APC_MENU_DISABLED     8'h00
`define APC_POS_WIDTH         32
`define APC_SLOT_RESET        3'h0
`define APC_HOLD_CYCLES       4'h2
`endif

// [design/apc_pkg.sv]
// Purpose: types for the absolute position control block
// Assumes: constants come from apc_params.svh
// Notes:   none
package apc_pkg;
  typedef enum logic [2:0] {
    APC_IDLE, APC_MOVE, APC_DECEL, APC_LOCK, APC_DONE
  } apc_state_t;
  typedef logic signed [31:0] apc_pos_t;
endpackage

// [design/apc_pos_counter.sv]
// Purpose: signed up/down position counter
// Assumes: step and up are synchronised already
// Notes:   counts whether or not the drive output is active
`timescale 1ns/10ps
`default_nettype none
module apc_pos_counter (
  input  wire logic clock_i,
  input  wire logic rstn_i,
  apc_enc_if.counter enc
);
  typedef struct packed {
    apc_pkg::apc_pos_t pos;
  } apc_cnt_st_t;
  apc_cnt_st_t st;
  apc_cnt_st_t next_st;

  // clear wins, else count per edge
  always_comb begin
    next_st = st;
    if (enc.clear) begin
      next_st.pos = '0;
    end else if (enc.step) begin
      next_st.pos = enc.up ? st.pos + 32'sd1 : st.pos - 32'sd1;
    end
  end

  // power-up origin is zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign enc.pos = st.pos;

  a_clear_zero: assert property (@(posedge clock_i)
    disable iff (!rstn_i) enc.clear |=> enc.pos == 0)
    else $error("clear did not zero");
  a_step_count: assert property (@(posedge clock_i)
    disable iff (!rstn_i)
    (enc.step && enc.up && !enc.clear) |=> enc.pos == $past(enc.pos) + 1)
    else $error("up step miscounted");
endmodule // apc_pos_counter
`default_nettype wire

// [design/apc_top.sv]
// Purpose: absolute position control of a motor drive
// Assumes: settings are static codes; terminals asynchronous
// Notes:   speed profile itself is outside; block gives run/dir/decel
`timescale 1ns/10ps
`default_nettype none
`include "apc_params.svh"
module apc_top (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  vf_curve_select_i,
  input  wire logic [7:0]  control_pulse_setting_i,
  input  wire logic [7:0]  reset_mode_select_i,
  input  wire logic [7:0]  display_group_select_i,
  input  wire logic [7:0]  terminal_function_i,
  input  wire logic        speed_position_select_terminal_i,
  input  wire logic        position_counter_clear_terminal_i,
  input  wire logic        torque_control_enable_terminal_i,
  input  wire logic        pulse_train_enable_terminal_i,
  input  wire logic        orientation_teach_terminal_i,
  input  wire logic        reset_terminal_i,
  input  wire logic        run_i,
  input  wire logic        keypad_save_key_i,
  input  wire logic        keypad_scroll_i,
  input  wire logic [3:0]  menu_index_i,
  input  wire logic [7:0]  menu_target_i,
  input  wire logic [2:0]  teaching_slot_select_i,
  input  wire logic        slot_select_load_i,
  input  wire logic [2:0]  target_select_i,
  input  wire logic [1:0]  zero_return_mode_i,
  input  wire logic        zero_return_i,
  input  wire logic        home_search_req_i,
  input  wire logic        enc_a_i,
  input  wire logic        enc_b_i,
  input  wire logic [31:0] slow_distance_i,
  output logic             auto_position_control_mode_o,
  output logic             motor_run_o,
  output logic             motor_dir_o,
  output logic             decel_o,
  output logic             servo_lock_o,
  output logic             position_done_o,
  output logic             home_search_o,
  output logic             zero_return_busy_o,
  output logic [1:0]       zero_return_mode_o,
  output logic [31:0]      position_o,
  output logic [15:0]      position_display_o,
  output logic [31:0]      deviation_o,
  output logic [2:0]       teaching_slot_o,
  output logic             user_menu_only_o,
  output logic [7:0]       menu_pointer_o
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    apc_pkg::apc_state_t fsm;
    logic [1:0]  a_sync;
    logic [1:0]  a_meta;
    logic [1:0]  b_sync;
    logic [1:0]  b_meta;
    logic [1:0]  t_meta;
    logic [1:0]  t_sync;
    logic [1:0]  rst_meta;
    logic [1:0]  rst_sync;
    logic        save_d;
    logic        run_o;
    logic        dir;
    logic        decel;
    logic        lock;
    logic        done;
    logic        search;
    logic        homing;
    logic [1:0]  zmode;
    logic [31:0] dev;
    logic [15:0] disp;
    logic [2:0]  slot;
    logic        menu_only;
    logic [7:0]  mptr;
    logic        auto_position_control_mode;
    apc_pkg::apc_pos_t tgt;
  } apc_st_t;
  apc_st_t st;
  apc_st_t next_st;

  apc_pkg::apc_pos_t slots [0:`APC_SLOT_COUNT-1];
  logic [7:0]        menu  [0:`APC_MENU_COUNT-1];

  apc_enc_if enc ();
  apc_pos_counter u_cnt (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .enc     (enc)
  );

  // ****************************************************************
  // combinational decode
  // ****************************************************************
  logic              mode_ok;
  logic              hires;
  logic              teach_en;
  logic              pos_sel;
  logic              a_edge;
  logic              b_edge;
  logic              clr_req;
  apc_pkg::apc_pos_t err;
  apc_pkg::apc_pos_t abs_err;
  logic [31:0]       mag;

  // mode qualification
  always_comb begin
    hires    = control_pulse_setting_i == `APC_PULSE_ABS_HIRES;
    mode_ok  = vf_curve_select_i == `APC_VF_SENSOR_VECTOR &&
               (control_pulse_setting_i == `APC_PULSE_ABS || hires);
    teach_en = terminal_function_i == `APC_FUNC_ORIENT &&
               (control_pulse_setting_i == `APC_PULSE_ABS || hires) &&
               st.t_sync[1];
    pos_sel  = terminal_function_i != `APC_FUNC_SPEED_POS ||
               speed_position_select_terminal_i;
  end

  // encoder edges: x4 counts every edge, x1 only rising a
  always_comb begin
    a_edge = st.a_sync[1] ^ st.a_sync[0];
    b_edge = st.b_sync[1] ^ st.b_sync[0];
    enc.step = hires ? (a_edge | b_edge)
                     : (a_edge & st.a_sync[0]);
    enc.up   = hires ? (st.a_sync[0] ^ st.b_sync[1])
                     : ~st.b_sync[0];
    clr_req  = position_counter_clear_terminal_i ||
               (st.rst_sync[1] &&
                reset_mode_select_i != `APC_RESET_TRIP_ONLY);
    enc.clear = clr_req;
  end

  // error sign drives direction, magnitude drives decel
  always_comb begin
    err     = st.tgt - enc.pos;
    abs_err = err[31] ? -err : err;
    mag     = abs_err;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st        = st;
    next_st.a_meta = {st.a_meta[0], enc_a_i};
    next_st.a_sync = {st.a_sync[0], st.a_meta[1]};
    next_st.b_meta = {st.b_meta[0], enc_b_i};
    next_st.b_sync = {st.b_sync[0], st.b_meta[1]};
    next_st.t_meta = {st.t_meta[0], orientation_teach_terminal_i};
    next_st.t_sync = {st.t_sync[0], st.t_meta[1]};
    next_st.rst_meta = {st.rst_meta[0], reset_terminal_i};
    next_st.rst_sync = {st.rst_sync[0], st.rst_meta[1]};
    next_st.save_d = keypad_save_key_i;
    next_st.auto_position_control_mode    = mode_ok;
    next_st.tgt    = slots[target_select_i];
    next_st.dev    = clr_req ? 32'h00000000 : err;
    next_st.disp   = enc.pos[31:16];
    next_st.menu_only = display_group_select_i == `APC_DISP_USER_ONLY;
    next_st.mptr   = menu[menu_index_i];
    // homing blocks search; search disabled in position mode
    next_st.homing = zero_return_i;
    next_st.zmode  = zero_return_mode_i;
    next_st.search = home_search_req_i && !zero_return_i &&
                     !mode_ok;
    if (slot_select_load_i) begin
      next_st.slot = teaching_slot_select_i;
    end
    // sequencer: run sense only starts/stops, not direction
    unique case (st.fsm)
      apc_pkg::APC_IDLE: begin
        next_st.run_o = 1'b0;
        next_st.lock  = 1'b0;
        next_st.decel = 1'b0;
        next_st.done  = 1'b0;
        if (run_i && teach_en) begin
          next_st.fsm   = apc_pkg::APC_MOVE;
          next_st.run_o = 1'b1;
        end else if (run_i && mode_ok && pos_sel) begin
          if (err == 0) begin
            next_st.fsm  = apc_pkg::APC_DONE;
            next_st.done = 1'b1;
          end else begin
            next_st.fsm   = apc_pkg::APC_MOVE;
            next_st.run_o = 1'b1;
            next_st.dir   = ~err[31];
          end
        end
      end
      apc_pkg::APC_MOVE: begin
        next_st.dir = teach_en ? st.dir : ~err[31];
        if (!run_i) begin
          next_st.fsm   = apc_pkg::APC_IDLE;
          next_st.run_o = 1'b0;
        end else if (!teach_en && err == 0) begin
          next_st.fsm   = apc_pkg::APC_LOCK;
          next_st.run_o = 1'b0;
          next_st.lock  = 1'b1;
          next_st.done  = 1'b1;
        end else if (!teach_en && mag <= slow_distance_i) begin
          next_st.fsm   = apc_pkg::APC_DECEL;
          next_st.decel = 1'b1;
        end
      end
      apc_pkg::APC_DECEL: begin
        next_st.dir = ~err[31];
        if (!run_i) begin
          next_st.fsm   = apc_pkg::APC_IDLE;
          next_st.run_o = 1'b0;
          next_st.decel = 1'b0;
        end else if (err == 0) begin
          next_st.fsm   = apc_pkg::APC_LOCK;
          next_st.run_o = 1'b0;
          next_st.decel = 1'b0;
          next_st.lock  = 1'b1;
          next_st.done  = 1'b1;
        end
      end
      apc_pkg::APC_LOCK: begin
        if (!run_i) begin
          next_st.fsm  = apc_pkg::APC_IDLE;
          next_st.lock = 1'b0;
          next_st.done = 1'b0;
        end
      end
      apc_pkg::APC_DONE: begin
        if (!run_i) begin
          next_st.fsm  = apc_pkg::APC_IDLE;
          next_st.done = 1'b0;
        end
      end
      default: next_st.fsm = apc_pkg::APC_IDLE;  // unused codes recover
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st      <= '0;
      st.fsm  <= apc_pkg::APC_IDLE;
      st.slot <= `APC_SLOT_RESET;
    end else begin
      st <= next_st;
    end
  end

  // teach memory and user menu pointers, no reset on arrays
  always_ff @(posedge clock_i) begin
    if (keypad_save_key_i && !st.save_d && teach_en) begin
      slots[st.slot] <= enc.pos;
    end
    if (keypad_scroll_i && menu_index_i < 4'(`APC_MENU_COUNT)) begin
      menu[menu_index_i] <= menu_target_i;
    end
  end

  // outputs; torque and pulse-train enables are not read
  assign auto_position_control_mode_o = st.auto_position_control_mode;
  assign motor_run_o        = st.run_o;
  assign motor_dir_o        = st.dir;
  assign decel_o            = st.decel;
  assign servo_lock_o       = st.lock;
  assign position_done_o    = st.done;
  assign home_search_o      = st.search;
  assign zero_return_busy_o = st.homing;
  assign zero_return_mode_o = st.zmode;
  assign position_o         = enc.pos;
  assign position_display_o = st.disp;
  assign deviation_o        = st.dev;
  assign teaching_slot_o    = st.slot;
  assign user_menu_only_o   = st.menu_only;
  assign menu_pointer_o     = st.mptr;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_mode_gate: assert property (@(posedge clock_i)
    disable iff (!rstn_i) (st.fsm == apc_pkg::APC_IDLE && !mode_ok &&
    !teach_en) |=> !st.run_o) else $error("run outside position mode");
  a_zero_done: assert property (@(posedge clock_i)
    disable iff (!rstn_i) (st.fsm == apc_pkg::APC_IDLE && run_i && mode_ok
    && pos_sel && !teach_en && err == 0) |=> (st.done && !st.run_o))
    else $error("zero target energised motor");
  a_lock_hold: assert property (@(posedge clock_i)
    disable iff (!rstn_i) (st.fsm == apc_pkg::APC_LOCK && run_i) |=> st.lock)
    else $error("lock dropped while running");
  a_no_search: assert property (@(posedge clock_i)
    disable iff (!rstn_i) zero_return_i |=> !st.search)
    else $error("search during zero return");
  a_slot_reset: assert property (@(posedge clock_i)
    $rose(rstn_i) |-> st.slot == 3'h0)
    else $error("slot not zero after reset");
  a_dev_clear: assert property (@(posedge clock_i)
    disable iff (!rstn_i) position_counter_clear_terminal_i |=> st.dev == 0)
    else $error("deviation not cleared");
  a_menu_only: assert property (@(posedge clock_i)
    disable iff (!rstn_i) (display_group_select_i == 8'h02) |=> st.menu_only)
    else $error("menu-only not shown");
  a_dir_sign: assert property (@(posedge clock_i)
    disable iff (!rstn_i) (st.fsm == apc_pkg::APC_IDLE && run_i && mode_ok
    && pos_sel && !teach_en && err != 0) |=> st.dir == !$past(err[31]))
    else $error("direction not from error sign");
  c_lock: cover property (@(posedge clock_i) st.fsm == apc_pkg::APC_LOCK);
  c_decel: cover property (@(posedge clock_i) st.fsm == apc_pkg::APC_DECEL);
  c_done: cover property (@(posedge clock_i) st.fsm == apc_pkg::APC_DONE);
endmodule // apc_top
`default_nettype wire
